/* File: dv/osl_osc_model.sv */
// partner model: oscillator sources that report failure when the bench commands it
`timescale 1ns/10ps
`default_nettype none
module osl_osc_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] fail_cmd,
    output logic primary_osc_fail,
    output logic watchdog_osc_fail
);
    // failure levels are synchronous and only move just after a clock edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_osc_fail <= 1'b0;
            watchdog_osc_fail <= 1'b0;
        end else begin
            primary_osc_fail <= fail_cmd[0];
            watchdog_osc_fail <= fail_cmd[1];
        end
    end
endmodule : osl_osc_model
`default_nettype wire

/* File: dv/tb.sv */
// testbench: self-checking bench of the oscillator select lock against a queue-free integer model
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb;
    // ************************************************************
    // signals, design and partner
    // ************************************************************
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pfen, wfen, recover, irq, pfail, wfail;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0] fail_cmd;
    logic [2:0] sel;
    logic [4:0] onehot;
    int compares, miscompares, m_ctrl, m_state, m_stat, m_mask;
    logic [7:0] v;
    osl_top u_osl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primary_osc_fail(pfail), .watchdog_osc_fail(wfail), .system_clock_source_select(sel),
        .clock_source_onehot(onehot), .primary_osc_fail_detect_enable(pfen),
        .watchdog_osc_fail_detect_enable(wfen), .primary_recover(recover), .irq(irq));
    osl_osc_model u_osl_osc_model (.pclk(pclk), .presetn(presetn), .fail_cmd(fail_cmd),
        .primary_osc_fail(pfail), .watchdog_osc_fail(wfail));
    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ************************************************************
    // bus tasks and model
    // ************************************************************
    task print_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rdata);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr_en; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            print_verdict;
        end
        rdata = prdata;
        `CHK("slverr", !(a inside {8'h00, 8'h04, 8'h08, 8'h0C}), pslverr)
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // irq level follows unmasked sticky status
    task settle;
        repeat (2) @(posedge pclk);
        `CHK("irq", |(m_stat[3:0] & m_mask[3:0]), irq)
    endtask : settle
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r, junk;
        r = $urandom;
        apb(1'b1, a, {r[31:8], d}, junk);
        if (a == osl_pkg::OSL_OFF_IRQ_MASK) m_mask = d & 8'h0F;
        if (a == osl_pkg::OSL_OFF_CTRL) begin
            if (m_state == 2) begin
                m_ctrl = d; m_state = 0; m_stat |= 1;
            end else if (m_state == 1) begin
                if (d == osl_pkg::OSL_UNLOCK_SECOND) m_state = 2;
                else begin
                    m_state = 0; m_stat |= 2;
                end
            end else if (d == osl_pkg::OSL_UNLOCK_FIRST) m_state = 1;
        end
        settle;
    endtask : wr
    task rd(input logic [7:0] a);
        int e;
        logic [31:0] d;
        case (a)
            osl_pkg::OSL_OFF_CTRL: e = m_ctrl;
            osl_pkg::OSL_OFF_STATUS: e = {m_state == 2, m_state == 1};
            osl_pkg::OSL_OFF_IRQ_STAT: e = m_stat;
            osl_pkg::OSL_OFF_IRQ_MASK: e = m_mask;
            default: e = 0;
        endcase
        apb(1'b0, a, 32'h0000_0000, d);
        `CHK("prdata", e, d)
        if (a == osl_pkg::OSL_OFF_IRQ_STAT) m_stat = 0;
    endtask : rd
    // decoded clock source and enables one cycle on
    task out_chk;
        @(posedge pclk);
        `CHK("select", m_ctrl[2:0], sel)
        `CHK("onehot", (m_ctrl[2:0] < 5) ? (1 << m_ctrl[2:0]) : 0, onehot)
        `CHK("primary enable", m_ctrl[4], pfen)
        `CHK("watchdog enable", m_ctrl[3], wfen)
    endtask : out_chk
    // both sources fail for three cycles
    task fail_pulse;
        @(posedge pclk);
        fail_cmd <= 2'b11;
        repeat (3) @(posedge pclk);
        `CHK("recover", m_ctrl[4], recover)
        fail_cmd <= 2'b00;
        m_stat |= (m_ctrl[4] << 2) | (m_ctrl[3] << 3);
        repeat (2) @(posedge pclk);
        settle;
    endtask : fail_pulse
    task do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m_ctrl = 0; m_state = 0; m_stat = 0; m_mask = 0;
    endtask : do_reset
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (100000) @(posedge pclk);
        miscompares++;
        print_verdict;
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; fail_cmd = 2'b00;
        m_ctrl = 0; m_state = 0; m_stat = 0; m_mask = 0; compares = 0; miscompares = 0;
        void'($urandom(30870));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00); rd(8'h04); rd(8'h0C); out_chk;
        wr(8'h00, 8'h13); rd(8'h00);
        for (int c = 0; c < 8; c++) begin
            v = 8'($urandom & 32'h18) | 8'(c);
            wr(8'h00, osl_pkg::OSL_UNLOCK_FIRST);
            wr(8'h0C, 8'($urandom % 16)); rd(8'h0C);
            rd(8'h04); wr(8'h10, 8'h55); rd(8'h10);
            wr(8'h00, osl_pkg::OSL_UNLOCK_SECOND); rd(8'h04); rd(8'h08);
            // software lets the chosen source settle first
            repeat (4) @(posedge pclk);
            wr(8'h00, v); out_chk; rd(8'h00); rd(8'h04);
            wr(8'h00, {3'b010, ~v[4:0]}); rd(8'h00);
            fail_pulse;
            rd(8'h08);
        end
        wr(8'h00, 8'h18); wr(8'h00, 8'hE7); wr(8'h00, 8'hE7); wr(8'h00, 8'h18);
        wr(8'h00, 8'h02); rd(8'h00); rd(8'h08);
        wr(8'h00, 8'hE7); wr(8'h00, 8'h18); do_reset;
        wr(8'h00, 8'h03); rd(8'h00); rd(8'h04); out_chk;
        print_verdict;
    end
endmodule : tb
`default_nettype wire

/* File: logic/osl_apb_if.sv */
// interface: decoded register strobes between the apb slave and the lock core
`timescale 1ns/10ps
`default_nettype none
interface osl_reg_if;
    logic ctrl_wr;
    logic [7:0] wdata;
    logic [7:0] ctrl_q;
    logic [1:0] lock_state;
    modport core (input ctrl_wr, input wdata, output ctrl_q, output lock_state);
    modport bus (output ctrl_wr, output wdata, input ctrl_q, input lock_state);
endinterface : osl_reg_if
`default_nettype wire

/* File: logic/osl_lock_core.sv */
// module: unlock sequence tracker and protected oscillator control register
`timescale 1ns/10ps
`default_nettype none
module osl_lock_core (
    input wire logic pclk,
    input wire logic presetn,
    osl_reg_if.core rif,
    output logic updated,
    output logic bad_seq
);
    osl_pkg::osl_lock_t state_reg;
    logic [7:0] ctrl_reg;

    // ************************************************************
    // unlock tracker: only writes to the control register move it
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= osl_pkg::OSL_LOCKED;
        end else if (rif.ctrl_wr) begin
            case (state_reg)
                osl_pkg::OSL_LOCKED: begin
                    if (rif.wdata == osl_pkg::OSL_UNLOCK_FIRST) begin
                        state_reg <= osl_pkg::OSL_HALF;
                    end
                end
                osl_pkg::OSL_HALF: begin
                    if (rif.wdata == osl_pkg::OSL_UNLOCK_SECOND) begin
                        state_reg <= osl_pkg::OSL_OPEN;
                    end else begin
                        state_reg <= osl_pkg::OSL_LOCKED;
                    end
                end
                osl_pkg::OSL_OPEN: begin
                    state_reg <= osl_pkg::OSL_LOCKED;
                end
                default: begin
                    state_reg <= osl_pkg::OSL_LOCKED;
                end
            endcase
        end
    end

    // ************************************************************
    // protected register: loads only from the open state
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= osl_pkg::OSL_CTRL_RESET;
        end else if (rif.ctrl_wr && state_reg == osl_pkg::OSL_OPEN) begin
            ctrl_reg <= rif.wdata;
        end
    end

    // event pulses for the interrupt status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            updated <= 1'b0;
            bad_seq <= 1'b0;
        end else begin
            updated <= rif.ctrl_wr && state_reg == osl_pkg::OSL_OPEN;
            bad_seq <= rif.ctrl_wr && state_reg == osl_pkg::OSL_HALF
                && rif.wdata != osl_pkg::OSL_UNLOCK_SECOND;
        end
    end

    assign rif.ctrl_q = ctrl_reg;
    assign rif.lock_state = {state_reg == osl_pkg::OSL_OPEN, state_reg == osl_pkg::OSL_HALF};

    // ************************************************************
    // assertions
    // ************************************************************
    // second unlock value after the first opens the register for one write
    property p_unlock_load;
        @(posedge pclk) disable iff (!presetn)
        (rif.ctrl_wr && rif.wdata == osl_pkg::OSL_UNLOCK_SECOND && state_reg == osl_pkg::OSL_HALF)
        |=> (state_reg == osl_pkg::OSL_OPEN);
    endproperty
    a_unlock_load: assert property (p_unlock_load) else $error("unlock pair did not allow update");

    property p_relock;
        @(posedge pclk) disable iff (!presetn)
        (rif.ctrl_wr && state_reg == osl_pkg::OSL_OPEN)
        |=> (state_reg == osl_pkg::OSL_LOCKED) && updated && (ctrl_reg == $past(rif.wdata));
    endproperty
    a_relock: assert property (p_relock) else $error("register not relocked after update");

    property p_no_change;
        @(posedge pclk) disable iff (!presetn)
        (state_reg != osl_pkg::OSL_OPEN) |=> $stable(ctrl_reg);
    endproperty
    a_no_change: assert property (p_no_change) else $error("control changed while locked");

    property p_gap_hold;
        @(posedge pclk) disable iff (!presetn)
        (!rif.ctrl_wr) |=> $stable(state_reg);
    endproperty
    a_gap_hold: assert property (p_gap_hold) else $error("unlock progress disturbed by other access");

    property p_half_order;
        @(posedge pclk) disable iff (!presetn)
        (rif.ctrl_wr && state_reg == osl_pkg::OSL_LOCKED) |=> (state_reg != osl_pkg::OSL_OPEN);
    endproperty
    a_half_order: assert property (p_half_order) else $error("unlock skipped the first value");

    property p_bad_second;
        @(posedge pclk) disable iff (!presetn)
        (rif.ctrl_wr && state_reg == osl_pkg::OSL_HALF && rif.wdata != osl_pkg::OSL_UNLOCK_SECOND)
        |=> state_reg == osl_pkg::OSL_LOCKED ##1 $stable(ctrl_reg);
    endproperty
    a_bad_second: assert property (p_bad_second) else $error("wrong second value not rejected");
endmodule : osl_lock_core
`default_nettype wire

/* File: logic/osl_pkg.sv */
// package: register map, field layout and encodings of the oscillator select lock block
package osl_pkg;
    // ************************************************************
    // register offsets (byte addresses on apb)
    // ************************************************************
    localparam logic [7:0] OSL_OFF_CTRL = 8'h00;
    localparam logic [7:0] OSL_OFF_STATUS = 8'h04;
    localparam logic [7:0] OSL_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OSL_OFF_IRQ_MASK = 8'h0C;
    // ************************************************************
    // control register fields and values
    // ************************************************************
    localparam int OSL_POS_PRIMARY_FAIL_EN = 4;
    localparam int OSL_POS_WDOG_FAIL_EN = 3;
    localparam int OSL_POS_SEL_LSB = 0;
    localparam int OSL_SEL_W = 3;
    localparam logic [7:0] OSL_CTRL_RESET = 8'h00;
    localparam logic [7:0] OSL_UNLOCK_FIRST = 8'hE7;
    localparam logic [7:0] OSL_UNLOCK_SECOND = 8'h18;
    localparam logic [2:0] OSL_SEL_IPO_FAST = 3'h0;
    localparam logic [2:0] OSL_SEL_IPO_SLOW = 3'h1;
    localparam logic [2:0] OSL_SEL_CRYSTAL = 3'h2;
    localparam logic [2:0] OSL_SEL_WDOG = 3'h3;
    localparam logic [2:0] OSL_SEL_EXT_PIN = 3'h4;
    // ************************************************************
    // interrupt status bits
    // ************************************************************
    localparam int OSL_IRQ_W = 4;
    localparam int OSL_IRQ_UPDATE = 0;
    localparam int OSL_IRQ_BAD_SEQ = 1;
    localparam int OSL_IRQ_PRIMARY_FAIL = 2;
    localparam int OSL_IRQ_WDOG_FAIL = 3;
    localparam logic [3:0] OSL_IRQ_MASK_RESET = 4'h0;
    // unlock tracker states, one-hot
    typedef enum logic [2:0] {
        OSL_LOCKED = 3'b001,
        OSL_HALF = 3'b010,
        OSL_OPEN = 3'b100
    } osl_lock_t;
endpackage : osl_pkg

/* File: logic/osl_top.sv */
// module: apb top of the oscillator select lock, clock source decode and interrupts
// What this block does
// - unlock needs a write of E7 then a write of 18 to the control register
// - after unlock, the next control write loads and the register relocks
// - any other sequence of control writes leaves the register unchanged
// - unlock values must be ordered but other bus cycles may fall between them
// - accesses to other registers never disturb the unlock progress
// - select field picks fast rc, slow rc, crystal, watchdog osc, or external pin
// - primary fail enable bit turns primary failure detection and recovery on
// - watchdog fail enable bit turns watchdog oscillator failure detection on
`timescale 1ns/10ps
`default_nettype none
module osl_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_osc_fail,
    input wire logic watchdog_osc_fail,
    output logic [2:0] system_clock_source_select,
    output logic [4:0] clock_source_onehot,
    output logic primary_osc_fail_detect_enable,
    output logic watchdog_osc_fail_detect_enable,
    output logic primary_recover,
    output logic irq
);
    osl_reg_if rif ();
    logic updated;
    logic bad_seq;
    logic acc;
    logic mapped;
    logic [3:0] irq_stat_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] events;
    logic stat_rd;

    osl_lock_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif),
        .updated(updated),
        .bad_seq(bad_seq)
    );

    // ************************************************************
    // apb decode: one wait state, error on unmapped offsets
    // ************************************************************
    assign acc = psel && penable && !pready;
    assign mapped = paddr == osl_pkg::OSL_OFF_CTRL || paddr == osl_pkg::OSL_OFF_STATUS
        || paddr == osl_pkg::OSL_OFF_IRQ_STAT || paddr == osl_pkg::OSL_OFF_IRQ_MASK;
    assign rif.ctrl_wr = acc && pwrite && paddr == osl_pkg::OSL_OFF_CTRL;
    assign rif.wdata = pwdata[7:0];
    assign stat_rd = acc && !pwrite && paddr == osl_pkg::OSL_OFF_IRQ_STAT;

    // ready pulses one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc;
            pslverr <= acc && !mapped;
        end
    end

    // read data mux, registered with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (acc && !pwrite) begin
            case (paddr)
                osl_pkg::OSL_OFF_CTRL: prdata <= {24'h00_0000, rif.ctrl_q};
                osl_pkg::OSL_OFF_STATUS: prdata <= {30'h0000_0000, rif.lock_state};
                osl_pkg::OSL_OFF_IRQ_STAT: prdata <= {28'h000_0000, irq_stat_reg};
                osl_pkg::OSL_OFF_IRQ_MASK: prdata <= {28'h000_0000, irq_mask_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end else begin
            prdata <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // clock source and failure detect outputs
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_clock_source_select <= osl_pkg::OSL_CTRL_RESET[2:0];
            clock_source_onehot <= 5'h01;
            primary_osc_fail_detect_enable <= 1'b0;
            watchdog_osc_fail_detect_enable <= 1'b0;
        end else begin
            system_clock_source_select <= rif.ctrl_q[osl_pkg::OSL_POS_SEL_LSB +: osl_pkg::OSL_SEL_W];
            case (rif.ctrl_q[osl_pkg::OSL_POS_SEL_LSB +: osl_pkg::OSL_SEL_W])
                osl_pkg::OSL_SEL_IPO_FAST: clock_source_onehot <= 5'h01;
                osl_pkg::OSL_SEL_IPO_SLOW: clock_source_onehot <= 5'h02;
                osl_pkg::OSL_SEL_CRYSTAL: clock_source_onehot <= 5'h04;
                osl_pkg::OSL_SEL_WDOG: clock_source_onehot <= 5'h08;
                osl_pkg::OSL_SEL_EXT_PIN: clock_source_onehot <= 5'h10;
                default: clock_source_onehot <= 5'h00; // reserved codes select nothing
            endcase
            primary_osc_fail_detect_enable <= rif.ctrl_q[osl_pkg::OSL_POS_PRIMARY_FAIL_EN];
            watchdog_osc_fail_detect_enable <= rif.ctrl_q[osl_pkg::OSL_POS_WDOG_FAIL_EN];
        end
    end

    // recovery request only while primary detection is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_recover <= 1'b0;
        end else begin
            primary_recover <= primary_osc_fail && rif.ctrl_q[osl_pkg::OSL_POS_PRIMARY_FAIL_EN];
        end
    end

    // ************************************************************
    // interrupts: sticky status, cleared by read, set wins
    // ************************************************************
    always_comb begin
        events = '0;
        events[osl_pkg::OSL_IRQ_UPDATE] = updated;
        events[osl_pkg::OSL_IRQ_BAD_SEQ] = bad_seq;
        events[osl_pkg::OSL_IRQ_PRIMARY_FAIL] = primary_osc_fail && rif.ctrl_q[osl_pkg::OSL_POS_PRIMARY_FAIL_EN];
        events[osl_pkg::OSL_IRQ_WDOG_FAIL] = watchdog_osc_fail && rif.ctrl_q[osl_pkg::OSL_POS_WDOG_FAIL_EN];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= (stat_rd ? 4'h0 : irq_stat_reg) | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= osl_pkg::OSL_IRQ_MASK_RESET;
        end else if (acc && pwrite && paddr == osl_pkg::OSL_OFF_IRQ_MASK) begin
            irq_mask_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((stat_rd ? 4'h0 : irq_stat_reg) | events) & irq_mask_reg);
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    property p_select_follow;
        @(posedge pclk) disable iff (!presetn)
        (rif.ctrl_q[2:0] == osl_pkg::OSL_SEL_WDOG) |=> clock_source_onehot == 5'h08;
    endproperty
    a_select_follow: assert property (p_select_follow) else $error("watchdog source not selected");

    property p_pfail_gate;
        @(posedge pclk) disable iff (!presetn)
        (primary_osc_fail && !rif.ctrl_q[4]) |=> !primary_recover;
    endproperty
    a_pfail_gate: assert property (p_pfail_gate) else $error("recovery while detection disabled");

    property p_wfail_gate;
        @(posedge pclk) disable iff (!presetn)
        (watchdog_osc_fail && rif.ctrl_q[3] && !stat_rd) |=> irq_stat_reg[3];
    endproperty
    a_wfail_gate: assert property (p_wfail_gate) else $error("watchdog failure not flagged");
endmodule : osl_top
`default_nettype wire
